// ==== bench/timer_interrupt_and_access_test.sv ====
// Self-checking bench joining the timer unit end and the controller end
`timescale 1ns/10ps
`default_nettype none
`include "timer_defs.svh"

module timer_interrupt_and_access_test;
    import timer_pkg::*;
    localparam int NCH = `TMR_CHANNELS;
    logic           clk = 1'b0;
    logic           arst_n = 1'b0;
    logic [NCH-1:0] tick = '0;
    logic [NCH-1:0] tmask = '0;
    logic           cap_ev = 1'b0;
    logic           cmd_valid = 1'b0;
    logic           cmd_write = 1'b0;
    logic           cmd_clear = 1'b0;
    reg_sel_t       cmd_sel = '0;
    chan_t          cmd_chan = '0;
    word_t          cmd_wdata = '0;
    wire logic      cmd_ready, cmd_refused, rsp_valid, irq_pending;
    wire word_t     rsp_data;
    wire src_t      irq_source;
    wire logic [NCH-1:0] run_state;
    // Behavioural model of the channels
    int             cnt [NCH];
    int             cst [NCH];
    int             capv = 0;
    int             num_errors = 0;
    int             total_checks = 0;
    int             cycles = 0;
    logic [NCH-1:0] unf = '0, en = '0, run = '0;
    logic           capf = 1'b0;
    logic [1:0]     capc = 2'h0;
    word_t          rv;

    always #12.5 clk = ~clk;

    timer_link_if link (.clk(clk), .arst_n(arst_n));
    timer_unit_end #(.NCH(NCH)) timer_unit_end_i (.REF_CLK(clk), .ARST_N(arst_n),
        .COUNT_TICK(tick), .CAPTURE_EVENT(cap_ev), .RUN_STATE(run_state), .LINK(link));
    timer_ctrl_end timer_ctrl_end_i (.REF_CLK(clk), .ARST_N(arst_n),
        .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_WRITE(cmd_write),
        .CMD_CLEAR(cmd_clear), .CMD_SEL(cmd_sel), .CMD_CHAN(cmd_chan),
        .CMD_WDATA(cmd_wdata), .CMD_REFUSED(cmd_refused), .RSP_VALID(rsp_valid),
        .RSP_DATA(rsp_data), .IRQ_PENDING(irq_pending), .IRQ_SOURCE(irq_source),
        .LINK(link));
    timer_link_assertions timer_link_assertions_i (.clk(clk), .arst_n(arst_n),
        .req(link.req), .wr(link.wr), .sel(link.sel), .chan(link.chan),
        .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack),
        .irq_underflow(link.irq_underflow), .irq_capture(link.irq_capture));

    task automatic give_verdict();
        if (num_errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict

    // Ticks and captures land in the model at the same edge as in the design
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            give_verdict();
        end
        // Capture sees the counter from before this edge's step
        if (cap_ev && capc != 2'h0 && !capf) capv = cnt[2];
        if (cap_ev && capc != 2'h0) capf = 1'b1;
        for (int c = 0; c < NCH; c++) begin
            if (tick[c] && run[c] && cnt[c] == 0) begin
                cnt[c] = cst[c];
                unf[c] = 1'b1;
            end else if (tick[c] && run[c]) cnt[c]--;
        end
    end

    function automatic word_t model_read(reg_sel_t s, int c);
        case (s)
            `TMR_SEL_RUN:   return word_t'(run);
            `TMR_SEL_CTRL:  return {22'h0, c == 2 && capf, unf[c],
                                    (c == 2) ? capc : 2'h0, en[c], 5'h0};
            `TMR_SEL_CONST: return word_t'(cst[c]);
            `TMR_SEL_COUNT: return word_t'(cnt[c]);
            `TMR_SEL_CAPT:  return word_t'(capv);
            default:        return '0;
        endcase
    endfunction : model_read

    function automatic src_t model_src();
        for (int c = 0; c < 3; c++) if (unf[c] && en[c]) return src_t'(c);
        if (capf && capc == 2'h3) return `TMR_SRC_CAP2;
        for (int c = 3; c < NCH; c++) if (unf[c] && en[c]) return src_t'(c + 1);
        return `TMR_SRC_NONE;
    endfunction : model_src

    task automatic chk(string what, word_t exp, word_t got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic cmd(logic cl, logic w, reg_sel_t s, int c, word_t d, logic rf);
        int n;
        n = 0;
        @(posedge clk);
        #2;
        {cmd_clear, cmd_write, cmd_sel, cmd_chan, cmd_wdata} = {cl, w, s, chan_t'(c), d};
        cmd_valid = 1'b1;
        @(posedge clk);
        #2;
        cmd_valid = 1'b0;
        tick = tmask;
        while (rsp_valid !== 1'b1 && cmd_refused !== 1'b1 && n < 20) begin
            @(posedge clk);
            #2;
            tick = '0;
            n++;
        end
        chk("answer", 32'h1, word_t'(rsp_valid | cmd_refused));
        chk("refused", word_t'(rf), word_t'(cmd_refused));
        rv = rsp_data;
        if (!rf && cl) begin
            unf[c] = unf[c] & ~d[8];
            if (c == 2) capf = capf & ~d[9];
        end else if (!rf && w) begin
            case (s)
                `TMR_SEL_RUN:   run = d[NCH-1:0];
                `TMR_SEL_CONST: cst[c] = d;
                `TMR_SEL_COUNT: cnt[c] = d;
                default: begin
                    unf[c] = unf[c] & d[8];
                    en[c] = d[5];
                    if (c == 2) capf = capf & d[9];
                    if (c == 2) capc = d[7:6];
                end
            endcase
        end
    endtask : cmd

    task automatic rd(reg_sel_t s, int c);
        cmd(1'b0, 1'b0, s, c, '0, 1'b0);
        chk("read", model_read(s, c), rv);
    endtask : rd

    task automatic irq_chk();
        repeat (2) @(posedge clk);
        #2;
        chk("source", word_t'(model_src()), word_t'(irq_source));
        chk("pending", word_t'(model_src() != `TMR_SRC_NONE), word_t'(irq_pending));
    endtask : irq_chk

    task automatic pulse(logic [NCH-1:0] t, logic e);
        @(posedge clk);
        #2;
        {tick, cap_ev} = {t, e};
        @(posedge clk);
        #2;
        {tick, cap_ev} = '0;
    endtask : pulse

    initial begin
        int k;
        void'($urandom(32'hC5A9));
        for (int c = 0; c < NCH; c++) {cnt[c], cst[c]} = '0;
        repeat (18) @(posedge clk);
        chk("ready", 32'h1, word_t'(cmd_ready));
        irq_chk();
        arst_n = 1'b1;
        for (int c = 0; c < NCH; c++) begin
            k = 2 + $urandom % 8;
            cmd(0, 1, `TMR_SEL_CONST, c, word_t'(k), 0);
            cmd(0, 1, `TMR_SEL_COUNT, c, 32'h0, 0);
            cmd(0, 1, `TMR_SEL_CTRL, c, (c == 2) ? 32'hE0 : 32'h20, 0);
            rd(`TMR_SEL_CONST, c);
        end
        cmd(0, 1, `TMR_SEL_RUN, 0, 32'h1F, 0);
        chk("run_state", 32'h1F, word_t'(run_state));
        pulse('1, 0);
        irq_chk();
        rd(`TMR_SEL_COUNT, 0);
        rd(`TMR_SEL_CTRL, 3);
        pulse('0, 1);
        pulse(5'h04, 0);
        pulse('0, 1);
        rd(`TMR_SEL_CAPT, 2);
        rd(`TMR_SEL_COUNT, 2);
        // Decrement at the read edge must not be seen
        k = cnt[1];
        tmask = 5'h02;
        cmd(0, 0, `TMR_SEL_COUNT, 1, 32'h0, 0);
        chk("sync_read", word_t'(k), rv);
        cmd(0, 1, `TMR_SEL_RUN, 0, 32'h02, 0);
        cmd(0, 1, `TMR_SEL_COUNT, 1, 32'h5, 1);
        tmask = '0;
        pulse('0, 0);
        rd(`TMR_SEL_COUNT, 1);
        cmd(0, 1, `TMR_SEL_RUN, 0, 32'h0, 0);
        for (int c = 0; c < 3; c++) begin
            cmd(1, 0, `TMR_SEL_CTRL, c, 32'h100, 0);
            irq_chk();
            rd(`TMR_SEL_CTRL, c);
        end
        cmd(0, 1, `TMR_SEL_CTRL, 2, 32'h360, 0);
        irq_chk();
        rd(`TMR_SEL_CTRL, 2);
        cmd(0, 1, `TMR_SEL_CTRL, 3, 32'h100, 0);
        irq_chk();
        cmd(1, 0, `TMR_SEL_CTRL, 4, 32'h100, 0);
        irq_chk();
        cmd(1, 0, `TMR_SEL_CTRL, 2, 32'h200, 0);
        rd(`TMR_SEL_CTRL, 2);
        rd(3'h5, 0);
        give_verdict();
    end
endmodule : timer_interrupt_and_access_test
`default_nettype wire

// ==== bench/timer_link_assertions.sv ====
// Protocol and request-level checks on the timer unit link
`timescale 1ns/10ps
`default_nettype none
`include "timer_defs.svh"

module timer_link_assertions (
    // Clock and reset
    input wire logic                   clk,
    input wire logic                   arst_n,
    // Access
    input wire logic                   req,
    input wire logic                   wr,
    input wire timer_pkg::reg_sel_t    sel,
    input wire timer_pkg::chan_t       chan,
    input wire timer_pkg::word_t       wdata,
    input wire timer_pkg::word_t       rdata,
    input wire logic                   ack,
    // Requests
    input wire logic [`TMR_MAX_CH-1:0] irq_underflow,
    input wire logic                   irq_capture
);
    import timer_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    ack_follows_req_a: assert property (req |=> ack)
        else $error("no ack after request");
    ack_needs_req_a: assert property (ack |-> $past(req))
        else $error("ack without request");
    ack_pulse_a: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    req_spacing_a: assert property (req |=> !req)
        else $error("request while one outstanding");
    rdata_holds_a: assert property (!$stable(rdata) |-> $past(req && !wr))
        else $error("read data changed without read");
    ctrl_cap_only_a: assert property (req && !wr && sel == `TMR_SEL_CTRL
        && chan != 3'h2 |=> rdata[`TMR_BIT_CAPF] == 1'b0)
        else $error("capture flag outside channel 2");
    cap_level_a: assert property ($fell(irq_capture) |->
        $past(req && wr && sel == `TMR_SEL_CTRL && chan == 3'h2))
        else $error("capture request fell without control write");
    for (genvar c = 0; c < `TMR_MAX_CH; c++) begin : g_unf
        unf_level_a: assert property ($fell(irq_underflow[c]) |->
            $past(req && wr && sel == `TMR_SEL_CTRL && chan == 3'(c)))
            else $error("underflow request fell without control write");
    end

    cover property ($rose(irq_underflow[0]));
    cover property ($rose(irq_capture));
    cover property (req && !wr ##1 ack);
endmodule : timer_link_assertions
`default_nettype wire

// ==== design/timer_channel.sv ====
// One down-counting channel: counter, reload constant, underflow flag and request
`timescale 1ns/10ps
`default_nettype none
`include "timer_defs.svh"

module timer_channel (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             arst_n,
    // Counting
    input  wire logic             tick,
    input  wire logic             run,
    // Register writes
    input  wire logic             wr_ctrl,
    input  wire logic             wr_const,
    input  wire logic             wr_count,
    input  wire timer_pkg::word_t wdata,
    // State
    output var  timer_pkg::word_t counter,
    output var  timer_pkg::word_t constant,
    output logic                  flag,
    output logic                  enable,
    output logic                  irq
);
    import timer_pkg::*;

    word_t counter_reg;
    word_t constant_reg;
    logic  flag_reg;
    logic  enable_reg;
    logic  decrement;
    logic  underflow;

    assign decrement = tick & run;
    assign underflow = decrement & (counter_reg == `TMR_WORD_RST);

    // A software load wins over a coincident count step
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            counter_reg <= `TMR_WORD_RST;
        end else if (wr_count) begin
            counter_reg <= wdata;
        end else if (underflow) begin
            counter_reg <= constant_reg;
        end else if (decrement) begin
            counter_reg <= counter_reg - 32'h0000_0001;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            constant_reg <= `TMR_WORD_RST;
        end else if (wr_const) begin
            constant_reg <= wdata;
        end
    end

    // Writing 0 clears, writing 1 keeps; a new underflow beats the clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flag_reg <= 1'b0;
        end else if (underflow) begin
            flag_reg <= 1'b1;
        end else if (wr_ctrl && !wdata[`TMR_BIT_UNF]) begin
            flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            enable_reg <= 1'b0;
        end else if (wr_ctrl) begin
            enable_reg <= wdata[`TMR_BIT_UNDERFLOW_IRQ_ENABLE];
        end
    end

    assign counter  = counter_reg;
    assign constant = constant_reg;
    assign flag     = flag_reg;
    assign enable   = enable_reg;
    assign irq      = flag_reg & enable_reg;

endmodule : timer_channel
`default_nettype wire

// ==== design/timer_ctrl_end.sv ====
// Controller end: software access sequencer and fixed-priority request encoder
`timescale 1ns/10ps
`default_nettype none
`include "timer_defs.svh"

module timer_ctrl_end (
    // Clock and reset
    input  wire logic             REF_CLK,
    input  wire logic             ARST_N,
    // Software command
    input  wire logic             CMD_VALID,
    output logic                  CMD_READY,
    input  wire logic             CMD_WRITE,
    input  wire logic             CMD_CLEAR,
    input  wire timer_pkg::reg_sel_t CMD_SEL,
    input  wire timer_pkg::chan_t CMD_CHAN,
    input  wire timer_pkg::word_t CMD_WDATA,
    // Answer
    output logic                  CMD_REFUSED,
    output logic                  RSP_VALID,
    output var  timer_pkg::word_t RSP_DATA,
    // Interrupt controller view
    output logic                  IRQ_PENDING,
    output var  timer_pkg::src_t  IRQ_SOURCE,
    // Link to the timer unit
    timer_link_if.ctl             LINK
);
    import timer_pkg::*;

    ctrl_state_e             state_reg;
    logic                    req_reg;
    logic                    wr_reg;
    reg_sel_t                sel_reg;
    chan_t                   chan_reg;
    word_t                   wdata_reg;
    word_t                   clear_mask_reg;
    logic [`TMR_MAX_CH-1:0]  run_shadow_reg;
    logic                    refused_reg;
    logic                    rsp_valid_reg;
    word_t                   rsp_data_reg;
    logic                    irq_pending_reg;
    src_t                    irq_source_reg;
    logic                    halted_needed;
    logic                    refuse;
    word_t                   keep_flags;
    src_t                    src_next;

    assign CMD_READY = (state_reg == CS_IDLE);

    // Channel register writes other than flag clears are refused while that channel runs
    assign halted_needed = CMD_WRITE & ~CMD_CLEAR & (CMD_SEL != `TMR_SEL_RUN)
                         & (CMD_CHAN < chan_t'(`TMR_MAX_CH));
    assign refuse = halted_needed & run_shadow_reg[CMD_CHAN];

    // Flags not being cleared are written as 1 so they survive
    always_comb begin
        keep_flags                 = '0;
        keep_flags[`TMR_BIT_UNF]   = 1'b1;
        keep_flags[`TMR_BIT_CAPF]  = 1'b1;
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_reg      <= CS_IDLE;
            req_reg        <= 1'b0;
            wr_reg         <= 1'b0;
            sel_reg        <= `TMR_SEL_RUN;
            chan_reg       <= '0;
            wdata_reg      <= '0;
            clear_mask_reg <= '0;
            refused_reg    <= 1'b0;
            rsp_valid_reg  <= 1'b0;
        end else begin
            req_reg       <= 1'b0;
            refused_reg   <= 1'b0;
            rsp_valid_reg <= 1'b0;
            unique case (state_reg)
                CS_IDLE: begin
                    if (CMD_VALID && refuse) begin
                        refused_reg <= 1'b1;
                    end else if (CMD_VALID) begin
                        req_reg        <= 1'b1;
                        chan_reg       <= CMD_CHAN;
                        clear_mask_reg <= CMD_WDATA & keep_flags;
                        if (CMD_CLEAR) begin
                            wr_reg    <= 1'b0;
                            sel_reg   <= `TMR_SEL_CTRL;
                            state_reg <= CS_RMW_READ;
                        end else begin
                            wr_reg    <= CMD_WRITE;
                            sel_reg   <= CMD_SEL;
                            wdata_reg <= CMD_WDATA;
                            state_reg <= CS_WAIT;
                        end
                    end
                end
                CS_RMW_READ: begin
                    if (LINK.ack) begin
                        req_reg   <= 1'b1;
                        wr_reg    <= 1'b1;
                        wdata_reg <= (LINK.rdata | keep_flags) & ~clear_mask_reg;
                        state_reg <= CS_WAIT;
                    end
                end
                CS_WAIT: begin
                    if (LINK.ack) begin
                        rsp_valid_reg <= 1'b1;
                        state_reg     <= CS_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rsp_data_reg <= '0;
        end else if (state_reg == CS_WAIT && LINK.ack) begin
            rsp_data_reg <= LINK.rdata;
        end
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            run_shadow_reg <= '0;
        end else if (req_reg && wr_reg && sel_reg == `TMR_SEL_RUN) begin
            run_shadow_reg <= wdata_reg[`TMR_MAX_CH-1:0];
        end
    end

    // Fixed order: channel 0, 1, 2, capture, then channels 3 and 4
    always_comb begin
        src_next = `TMR_SRC_NONE;
        if (LINK.irq_underflow[0]) begin
            src_next = `TMR_SRC_UNF0;
        end else if (LINK.irq_underflow[1]) begin
            src_next = `TMR_SRC_UNF1;
        end else if (LINK.irq_underflow[2]) begin
            src_next = `TMR_SRC_UNF2;
        end else if (LINK.irq_capture) begin
            src_next = `TMR_SRC_CAP2;
        end else if (LINK.irq_underflow[3]) begin
            src_next = `TMR_SRC_UNF3;
        end else if (LINK.irq_underflow[4]) begin
            src_next = `TMR_SRC_UNF4;
        end
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            irq_pending_reg <= 1'b0;
            irq_source_reg  <= `TMR_SRC_NONE;
        end else begin
            irq_pending_reg <= (src_next != `TMR_SRC_NONE);
            irq_source_reg  <= src_next;
        end
    end

    assign LINK.req    = req_reg;
    assign LINK.wr     = wr_reg;
    assign LINK.sel    = sel_reg;
    assign LINK.chan   = chan_reg;
    assign LINK.wdata  = wdata_reg;
    assign CMD_REFUSED = refused_reg;
    assign RSP_VALID   = rsp_valid_reg;
    assign RSP_DATA    = rsp_data_reg;
    assign IRQ_PENDING = irq_pending_reg;
    assign IRQ_SOURCE  = irq_source_reg;

endmodule : timer_ctrl_end
`default_nettype wire

// ==== design/timer_unit_end.sv ====
// Timer unit end: channels, run bits, capture on channel 2, register access, requests
`timescale 1ns/10ps
`default_nettype none
`include "timer_defs.svh"

module timer_unit_end #(
    parameter int NCH = `TMR_CHANNELS
) (
    // Clock and reset
    input  wire logic           REF_CLK,
    input  wire logic           ARST_N,
    // Count steps from the prescaler, one per channel
    input  wire logic [NCH-1:0] COUNT_TICK,
    // Capture strobe from the channel 2 edge detector
    input  wire logic           CAPTURE_EVENT,
    // Channel run state
    output logic [NCH-1:0]      RUN_STATE,
    // Register access and interrupt requests
    timer_link_if.dev           LINK
);
    import timer_pkg::*;

    // Channels 3 and 4 are optional; capture needs channel 2
    if (NCH < 3 || NCH > `TMR_MAX_CH) begin : g_bad_nch
        $error("timer_unit_end: NCH must be 3 to 5");
    end

    // Access decode
    logic            chan_ok;
    logic            wr_any;
    logic            rd_any;
    logic [NCH-1:0]  chan_hit;
    logic [NCH-1:0]  wr_ctrl;
    logic [NCH-1:0]  wr_const;
    logic [NCH-1:0]  wr_count;
    logic            wr_run;
    logic            wr_cap_ctrl;

    // Channel state
    word_t           counter_w  [NCH];
    word_t           constant_w [NCH];
    logic [NCH-1:0]  flag_w;
    logic [NCH-1:0]  enable_w;
    logic [NCH-1:0]  irq_w;

    // Run bits and capture state
    logic [NCH-1:0]  run_reg;
    logic [1:0]      capture_control_reg;
    logic            capture_flag_reg;
    word_t           capture_value_reg;
    logic            capture_armed;

    // Read answer
    word_t           rdata_reg;
    word_t           rdata_next;
    logic            ack_reg;

    assign chan_ok = (LINK.chan < chan_t'(NCH));
    assign wr_any  = LINK.req & LINK.wr;
    assign rd_any  = LINK.req & ~LINK.wr;
    assign wr_run  = wr_any & (LINK.sel == `TMR_SEL_RUN);

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        assign chan_hit[c] = chan_ok & (LINK.chan == chan_t'(c));
        assign wr_ctrl[c]  = wr_any & chan_hit[c] & (LINK.sel == `TMR_SEL_CTRL);
        assign wr_const[c] = wr_any & chan_hit[c] & (LINK.sel == `TMR_SEL_CONST);
        assign wr_count[c] = wr_any & chan_hit[c] & (LINK.sel == `TMR_SEL_COUNT);

        timer_channel u_channel (
            .clk      (REF_CLK),
            .arst_n   (ARST_N),
            .tick     (COUNT_TICK[c]),
            .run      (run_reg[c]),
            .wr_ctrl  (wr_ctrl[c]),
            .wr_const (wr_const[c]),
            .wr_count (wr_count[c]),
            .wdata    (LINK.wdata),
            .counter  (counter_w[c]),
            .constant (constant_w[c]),
            .flag     (flag_w[c]),
            .enable   (enable_w[c]),
            .irq      (irq_w[c])
        );
    end

    // Run bits may change while counting; counters stay untouched
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            run_reg <= '0;
        end else if (wr_run) begin
            run_reg <= LINK.wdata[NCH-1:0];
        end
    end

    assign RUN_STATE = run_reg;

    // Capture control lives beside channel 2 control bits
    assign wr_cap_ctrl   = wr_ctrl[`TMR_CAPTURE_CH];
    assign capture_armed = CAPTURE_EVENT & (capture_control_reg != `TMR_CAPC_OFF);

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            capture_control_reg <= `TMR_CAPC_OFF;
        end else if (wr_cap_ctrl) begin
            capture_control_reg <= {LINK.wdata[`TMR_BIT_CAPC_HI],
                                    LINK.wdata[`TMR_BIT_CAPC_LO]};
        end
    end

    // A capture in the clearing cycle keeps the flag set
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            capture_flag_reg <= 1'b0;
        end else if (capture_armed) begin
            capture_flag_reg <= 1'b1;
        end else if (wr_cap_ctrl && !LINK.wdata[`TMR_BIT_CAPF]) begin
            capture_flag_reg <= 1'b0;
        end
    end

    // Old value held while a previous capture is still unserviced
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            capture_value_reg <= `TMR_WORD_RST;
        end else if (capture_armed && !capture_flag_reg) begin
            capture_value_reg <= counter_w[`TMR_CAPTURE_CH];
        end
    end

    // Readback; counter sampled before this edge's decrement lands
    always_comb begin
        rdata_next = '0;
        case (LINK.sel)
            `TMR_SEL_RUN: begin
                rdata_next[NCH-1:0] = run_reg;
            end
            `TMR_SEL_CTRL: begin
                for (int c = 0; c < NCH; c++) begin
                    if (chan_hit[c]) begin
                        rdata_next[`TMR_BIT_UNF]  = flag_w[c];
                        rdata_next[`TMR_BIT_UNDERFLOW_IRQ_ENABLE] = enable_w[c];
                    end
                end
                if (chan_hit[`TMR_CAPTURE_CH]) begin
                    rdata_next[`TMR_BIT_CAPF]    = capture_flag_reg;
                    rdata_next[`TMR_BIT_CAPC_HI] = capture_control_reg[1];
                    rdata_next[`TMR_BIT_CAPC_LO] = capture_control_reg[0];
                end
            end
            `TMR_SEL_CONST: begin
                for (int c = 0; c < NCH; c++) begin
                    if (chan_hit[c]) begin
                        rdata_next = constant_w[c];
                    end
                end
            end
            `TMR_SEL_COUNT: begin
                for (int c = 0; c < NCH; c++) begin
                    if (chan_hit[c]) begin
                        rdata_next = counter_w[c];
                    end
                end
            end
            `TMR_SEL_CAPT: begin
                if (chan_hit[`TMR_CAPTURE_CH]) begin
                    rdata_next = capture_value_reg;
                end
            end
            default: begin
                rdata_next = '0;
            end
        endcase
    end

    // Every access is answered one cycle later; unmapped reads give zero
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= LINK.req;
        end
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rdata_reg <= '0;
        end else if (rd_any) begin
            rdata_reg <= rdata_next;
        end
    end

    assign LINK.ack   = ack_reg;
    assign LINK.rdata = rdata_reg;

    // Request lines in channel order; absent channels stay quiet
    always_comb begin
        LINK.irq_underflow          = '0;
        LINK.irq_underflow[NCH-1:0] = irq_w;
    end

    assign LINK.irq_capture = capture_flag_reg
                            & (capture_control_reg == `TMR_CAPC_IRQ);

endmodule : timer_unit_end
`default_nettype wire

// ==== shared/timer_defs.svh ====
// Constants of the timer unit link, register layout and request priority codes
// Behaviour
// - Underflow request per channel, capture on channel 2
// - Underflow request equals flag AND enable
// - Capture request needs flag and control 11
// - Fixed priority: ch0, ch1, ch2, capture, ch3, ch4
// - Software stops a channel before writing it
// - Run writes, flag clears never disturb counting
// - Flag clear writes other control bits unchanged
// - Counter read returns value before coincident decrement
// - Reset clock divider before counting clock output
// - External count clock below quarter peripheral clock
// - Underflow sets flag, reloads constant, keeps counting
// - Capture copies counter only while flag clear
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

`define TMR_CHANNELS     5
`define TMR_MAX_CH       5
`define TMR_CHAN_W       3
`define TMR_CAPTURE_CH   2

// Register select codes
`define TMR_SEL_RUN      3'h0
`define TMR_SEL_CTRL     3'h1
`define TMR_SEL_CONST    3'h2
`define TMR_SEL_COUNT    3'h3
`define TMR_SEL_CAPT     3'h4

// Control register fields
`define TMR_BIT_CAPF     9
`define TMR_BIT_UNF      8
`define TMR_BIT_CAPC_HI  7
`define TMR_BIT_CAPC_LO  6
`define TMR_BIT_UNDERFLOW_IRQ_ENABLE     5
`define TMR_CAPC_IRQ     2'h3
`define TMR_CAPC_OFF     2'h0

// Reset values
`define TMR_WORD_RST     32'h0000_0000

// Priority codes of the requests, 0 is highest
`define TMR_SRC_UNF0     3'h0
`define TMR_SRC_UNF1     3'h1
`define TMR_SRC_UNF2     3'h2
`define TMR_SRC_CAP2     3'h3
`define TMR_SRC_UNF3     3'h4
`define TMR_SRC_UNF4     3'h5
`define TMR_SRC_NONE     3'h7

`endif

// ==== shared/timer_link_if.sv ====
// Register access and interrupt request link between timer unit and its controller
`timescale 1ns/10ps
`default_nettype none
`include "timer_defs.svh"

interface timer_link_if (
    input wire logic clk,
    input wire logic arst_n
);
    import timer_pkg::*;

    logic                    req;
    logic                    wr;
    reg_sel_t                sel;
    chan_t                   chan;
    word_t                   wdata;
    word_t                   rdata;
    logic                    ack;
    logic [`TMR_MAX_CH-1:0]  irq_underflow;
    logic                    irq_capture;

    modport dev (
        input  clk, arst_n, req, wr, sel, chan, wdata,
        output rdata, ack, irq_underflow, irq_capture
    );

    modport ctl (
        input  clk, arst_n, rdata, ack, irq_underflow, irq_capture,
        output req, wr, sel, chan, wdata
    );

endinterface : timer_link_if
`default_nettype wire

// ==== shared/timer_pkg.sv ====
// Types shared by both ends of the timer unit link
package timer_pkg;

    typedef logic [31:0] word_t;
    typedef logic [2:0]  reg_sel_t;
    typedef logic [2:0]  chan_t;
    typedef logic [2:0]  src_t;

    typedef enum logic [1:0] {
        CS_IDLE,
        CS_RMW_READ,
        CS_WAIT
    } ctrl_state_e;

endpackage : timer_pkg
